//--- src/uhlp_pkg.sv
// uhlp_pkg: offsets, field layout and carrier types of the list pointer bank.
// assumes a 32-bit apb slave with word-aligned registers.
package uhlp_pkg;
   localparam logic [7:0] OFF_CTRL_HEAD = 8'h20;
   localparam logic [7:0] OFF_CTRL_CUR = 8'h24;
   localparam logic [7:0] OFF_BULK_HEAD = 8'h28;
   localparam logic [7:0] OFF_BULK_CUR = 8'h2C;
   localparam logic [7:0] OFF_DONE_HEAD = 8'h30;
   localparam int ADDR_W = 8;
   // pointers are 16-byte aligned, bits 3..0 always zero
   localparam logic [31:0] PTR_MASK = 32'hFFFFFFF0;
   localparam logic [31:0] PTR_RESET = 32'h00000000;
   localparam logic [31:0] RD_UNMAPPED = 32'h00000000;

   // one update from the list engine: strobe plus new address
   typedef struct packed {
      logic wr;
      logic [31:0] addr;
   } uhlp_upd_s;
endpackage

//--- src/uhlp_regs.sv
// uhlp_regs: apb register bank holding the control, bulk and done list pointers.
// the list engine reads the pointers from the output ports and moves the
// current and done pointers through one-cycle update carriers.
// assumes the list engine is on pclk and drives its update strobes synchronously.
// assumes an apb master on the same clock; this slave never inserts wait states.
//
// Operation
// R1: the control head pointer at 0x20 is written by software, read by the engine, resets to 0.
// R2: the control current pointer at 0x24 is writable in bits 31..4 by software and engine.
// R3: the bulk head pointer at 0x28 is written by software, read by the engine, resets to 0.
// R4: the bulk current pointer at 0x2C is writable in bits 31..4 by software and engine.
// R5: the done head pointer at 0x30 is written only by the engine and is read-only to software.
// R6: bits 3..0 of every descriptor pointer stay zero, are unwritable and read as zero.
`timescale 1ns/1ps
module uhlp_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire uhlp_pkg::uhlp_upd_s ctrl_cur_upd,
   input wire uhlp_pkg::uhlp_upd_s bulk_cur_upd,
   input wire uhlp_pkg::uhlp_upd_s done_upd,
   output logic [31:0] control_head_addr,
   output logic [31:0] control_current_addr,
   output logic [31:0] bulk_head_addr,
   output logic [31:0] bulk_current_addr,
   output logic [31:0] done_queue_addr
);
   // register state and next values, one pair per pointer
   logic [31:0] ctrl_head_reg;
   logic [31:0] ctrl_head_next;
   logic [31:0] ctrl_cur_reg;
   logic [31:0] ctrl_cur_next;
   logic [31:0] bulk_head_reg;
   logic [31:0] bulk_head_next;
   logic [31:0] bulk_cur_reg;
   logic [31:0] bulk_cur_next;
   logic [31:0] done_reg;
   logic [31:0] done_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   // apb phase qualifiers: a write acts in the access phase, a read is
   // captured in the setup phase so that prdata can come from a flop
   logic wr_acc;
   logic rd_acc;
   logic mapped;

   // zero-wait slave: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & ~penable & ~pwrite;

   // address decode; unmapped reads give zero, unmapped writes are dropped
   always_comb begin
      case (paddr)
         uhlp_pkg::OFF_CTRL_HEAD,
         uhlp_pkg::OFF_CTRL_CUR,
         uhlp_pkg::OFF_BULK_HEAD,
         uhlp_pkg::OFF_BULK_CUR,
         uhlp_pkg::OFF_DONE_HEAD: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~mapped;

   // software write strikes, one per register; an access to an unmapped
   // offset raises none of them, so such a write is simply dropped
   logic wr_ctrl_head;
   logic wr_ctrl_cur;
   logic wr_bulk_head;
   logic wr_bulk_cur;
   logic wr_done_head;
   // a strike needs the access phase and an exact offset
   assign wr_ctrl_head = wr_acc & (paddr == uhlp_pkg::OFF_CTRL_HEAD); // R1
   assign wr_ctrl_cur = wr_acc & (paddr == uhlp_pkg::OFF_CTRL_CUR); // R2
   assign wr_bulk_head = wr_acc & (paddr == uhlp_pkg::OFF_BULK_HEAD); // R3
   assign wr_bulk_cur = wr_acc & (paddr == uhlp_pkg::OFF_BULK_CUR); // R4
   assign wr_done_head = wr_acc & (paddr == uhlp_pkg::OFF_DONE_HEAD); // R5

   // read selects, decoded in the setup cycle only; an unmapped read
   // raises none of them and returns the unmapped value
   logic rd_ctrl_head;
   logic rd_ctrl_cur;
   logic rd_bulk_head;
   logic rd_bulk_cur;
   logic rd_done_head;
   // a select needs the setup phase and an exact offset
   assign rd_ctrl_head = rd_acc & (paddr == uhlp_pkg::OFF_CTRL_HEAD);
   assign rd_ctrl_cur = rd_acc & (paddr == uhlp_pkg::OFF_CTRL_CUR);
   assign rd_bulk_head = rd_acc & (paddr == uhlp_pkg::OFF_BULK_HEAD);
   assign rd_bulk_cur = rd_acc & (paddr == uhlp_pkg::OFF_BULK_CUR);
   assign rd_done_head = rd_acc & (paddr == uhlp_pkg::OFF_DONE_HEAD);

   // engine strikes unpacked from their carriers; the engine may strike
   // in any cycle, including one in which software writes the same pointer
   logic eng_ctrl_cur;
   logic eng_bulk_cur;
   logic eng_done;
   assign eng_ctrl_cur = ctrl_cur_upd.wr; // R2
   assign eng_bulk_cur = bulk_cur_upd.wr; // R4
   assign eng_done = done_upd.wr; // R5

   // candidate values with the low nibble cleared once per source; the
   // mask keeps a misaligned descriptor address out of the bank
   logic [31:0] sw_ptr_val;
   logic [31:0] eng_ctrl_val;
   logic [31:0] eng_bulk_val;
   logic [31:0] eng_done_val;
   assign sw_ptr_val = pwdata & uhlp_pkg::PTR_MASK; // R6
   assign eng_ctrl_val = ctrl_cur_upd.addr & uhlp_pkg::PTR_MASK; // R6
   assign eng_bulk_val = bulk_cur_upd.addr & uhlp_pkg::PTR_MASK; // R6
   assign eng_done_val = done_upd.addr & uhlp_pkg::PTR_MASK; // R6

   // control list head: only software writes it and the engine only reads
   // it, so there is nothing to arbitrate
   always_comb begin
      ctrl_head_next = ctrl_head_reg;
      case (wr_ctrl_head)
         1'b1: begin
            // lands at the access edge, seen on the port right after that edge
            ctrl_head_next = sw_ptr_val; // R1 R6
         end
         default: begin
            // reads and other offsets leave the pointer as it is
            ctrl_head_next = ctrl_head_reg;
         end
      endcase
   end

   // control list head register; the async clear keeps the engine from
   // seeing a stale list head while the controller leaves reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_head_reg <= uhlp_pkg::PTR_RESET; // R1
      end else begin
         ctrl_head_reg <= ctrl_head_next;
      end
   end

   // control list current: the engine beats a software write in the same
   // cycle, since the engine reports where it really is in the list
   always_comb begin
      ctrl_cur_next = ctrl_cur_reg;
      case ({eng_ctrl_cur, wr_ctrl_cur})
         2'b01: begin
            ctrl_cur_next = sw_ptr_val; // R2 R6
         end
         2'b10,
         2'b11: begin
            // on a collision the software value is lost; a driver that
            // races the engine must read the pointer back
            ctrl_cur_next = eng_ctrl_val; // R2 R6
         end
         default: begin
            // no strike from either side
            ctrl_cur_next = ctrl_cur_reg;
         end
      endcase
   end

   // control list current register, cleared by reset so the engine
   // starts its walk from the head after every reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_cur_reg <= uhlp_pkg::PTR_RESET; // R2
      end else begin
         ctrl_cur_reg <= ctrl_cur_next;
      end
   end

   // bulk list head: only software writes it and the engine only reads
   // it, so there is nothing to arbitrate
   always_comb begin
      bulk_head_next = bulk_head_reg;
      case (wr_bulk_head)
         1'b1: begin
            // lands at the access edge, seen on the port right after that edge
            bulk_head_next = sw_ptr_val; // R3 R6
         end
         default: begin
            // reads and other offsets leave the pointer as it is
            bulk_head_next = bulk_head_reg;
         end
      endcase
   end

   // bulk list head register; the async clear keeps the engine from
   // seeing a stale list head while the controller leaves reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bulk_head_reg <= uhlp_pkg::PTR_RESET; // R3
      end else begin
         bulk_head_reg <= bulk_head_next;
      end
   end

   // bulk list current: the engine beats a software write in the same
   // cycle, since the engine reports where it really is in the list
   always_comb begin
      bulk_cur_next = bulk_cur_reg;
      case ({eng_bulk_cur, wr_bulk_cur})
         2'b01: begin
            bulk_cur_next = sw_ptr_val; // R4 R6
         end
         2'b10,
         2'b11: begin
            // on a collision the software value is lost; a driver that
            // races the engine must read the pointer back
            bulk_cur_next = eng_bulk_val; // R4 R6
         end
         default: begin
            // no strike from either side
            bulk_cur_next = bulk_cur_reg;
         end
      endcase
   end

   // bulk list current register, cleared by reset so the engine
   // starts its walk from the head after every reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bulk_cur_reg <= uhlp_pkg::PTR_RESET; // R4
      end else begin
         bulk_cur_reg <= bulk_cur_next;
      end
   end

   // done queue head: only the engine moves it; a software write is
   // decoded on purpose so that dropping it is explicit rather than
   // an accident of the decode
   always_comb begin
      done_next = done_reg;
      case ({eng_done, wr_done_head})
         2'b01: begin
            // software may not move the done head
            done_next = done_reg; // R5
         end
         2'b10,
         2'b11: begin
            // the engine value stands whether or not software wrote in
            // the same cycle
            done_next = eng_done_val; // R5 R6
         end
         default: begin
            // no strike from the engine
            done_next = done_reg;
         end
      endcase
   end

   // done queue head register, cleared by reset so an empty queue reads
   // as a null pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= uhlp_pkg::PTR_RESET; // R5
      end else begin
         done_reg <= done_next;
      end
   end

   // read mux, captured at the setup edge so prdata is a flop by the access
   // phase; the price is that an engine update in that same setup cycle is
   // not seen by the read, only by the next one
   always_comb begin
      rdata_next = rdata_reg;
      if (rd_ctrl_head) begin
         rdata_next = ctrl_head_reg; // R1
      end else if (rd_ctrl_cur) begin
         rdata_next = ctrl_cur_reg; // R2
      end else if (rd_bulk_head) begin
         rdata_next = bulk_head_reg; // R3
      end else if (rd_bulk_cur) begin
         rdata_next = bulk_cur_reg; // R4
      end else if (rd_done_head) begin
         rdata_next = done_reg; // R5
      end else if (rd_acc) begin
         rdata_next = uhlp_pkg::RD_UNMAPPED;
      end
   end

   // read data register; it holds until the next read setup, so a write
   // in between does not disturb what the last read returned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= uhlp_pkg::RD_UNMAPPED;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // pointer outputs to the list engine come straight from the flops, so
   // the engine sees a change right after the edge that makes it
   assign prdata = rdata_reg;
   assign control_head_addr = ctrl_head_reg; // R1
   assign control_current_addr = ctrl_cur_reg; // R2
   assign bulk_head_addr = bulk_head_reg; // R3
   assign bulk_current_addr = bulk_cur_reg; // R4
   assign done_queue_addr = done_reg; // R5
endmodule // uhlp_regs

//--- bench/uhlp_regs_sva.sv
// uhlp_regs_sva: assertions on the list pointer bank ports.
// assumes a single pclk domain; bound onto every uhlp_regs.
`timescale 1ns/1ps
module uhlp_regs_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] control_head_addr,
   input wire logic [31:0] control_current_addr,
   input wire logic [31:0] bulk_head_addr,
   input wire logic [31:0] bulk_current_addr,
   input wire logic [31:0] done_queue_addr,
   input wire uhlp_pkg::uhlp_upd_s ctrl_cur_upd,
   input wire uhlp_pkg::uhlp_upd_s bulk_cur_upd,
   input wire uhlp_pkg::uhlp_upd_s done_upd
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a write only counts on the access edge, never in setup
   wire logic sw_wr = psel && penable && pwrite;
   // a read is captured at its setup edge
   wire logic sw_rd = psel && !penable && !pwrite;
   a_read_done: assert property (sw_rd && paddr == 8'h30 |=>
      prdata == $past(done_queue_addr)) else $error("done read");
   a_unmapped_err: assert property (pslverr == (psel && penable &&
      !(paddr inside {8'h20, 8'h24, 8'h28, 8'h2C, 8'h30}))) else $error("slverr");
   a_ready_high: assert property (pready) else $error("ready low");
   a_ctrl_head_wr: assert property (sw_wr && paddr == 8'h20 |=>
      control_head_addr == ($past(pwdata) & 32'hFFFFFFF0)) else $error("ctrl head");
   a_ctrl_cur_upd: assert property (ctrl_cur_upd.wr |=>
      control_current_addr == ($past(ctrl_cur_upd.addr) & 32'hFFFFFFF0)) else $error("ctrl cur");
   a_bulk_head_wr: assert property (sw_wr && paddr == 8'h28 |=>
      bulk_head_addr == ($past(pwdata) & 32'hFFFFFFF0)) else $error("bulk head");
   a_bulk_cur_upd: assert property (bulk_cur_upd.wr |=>
      bulk_current_addr == ($past(bulk_cur_upd.addr) & 32'hFFFFFFF0)) else $error("bulk cur");
   a_done_upd: assert property (done_upd.wr |=>
      done_queue_addr == ($past(done_upd.addr) & 32'hFFFFFFF0)) else $error("done upd");
   a_done_ro: assert property (sw_wr && paddr == 8'h30 && !done_upd.wr |=>
      $stable(done_queue_addr)) else $error("done written");
   a_low_bits_zero: assert property (((control_head_addr | control_current_addr |
      bulk_head_addr | bulk_current_addr | done_queue_addr) & 32'hF) == 0) else $error("low bits");
endmodule // uhlp_regs_sva
bind uhlp_regs uhlp_regs_sva u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .control_head_addr(control_head_addr), .control_current_addr(control_current_addr),
   .bulk_head_addr(bulk_head_addr), .bulk_current_addr(bulk_current_addr),
   .done_queue_addr(done_queue_addr), .ctrl_cur_upd(ctrl_cur_upd),
   .bulk_cur_upd(bulk_cur_upd), .done_upd(done_upd)
);

//--- bench/testbench.sv
// testbench: table of apb readbacks, then engine updates and a mid-run reset.
// assumes uhlp_regs answers with pready and takes one-cycle engine strobes.
`timescale 1ns/1ps
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, control_head_addr, control_current_addr;
   logic [31:0] bulk_head_addr, bulk_current_addr, done_queue_addr;
   uhlp_pkg::uhlp_upd_s ctrl_cur_upd = '0, bulk_cur_upd = '0, done_upd = '0;
   int errors = 0, n_tests = 0, cyc = 0;
   // rows: offset, readback after an all-ones write, error flag; 0x34 is unmapped
   logic [7:0] ra [6] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34};
   logic [31:0] re [6] = '{32'hFFFFFFF0, 32'hFFFFFFF0, 32'hFFFFFFF0, 32'hFFFFFFF0, 32'h0, 32'h0};
   logic ee [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   uhlp_regs DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ctrl_cur_upd(ctrl_cur_upd), .bulk_cur_upd(bulk_cur_upd), .done_upd(done_upd),
      .control_head_addr(control_head_addr), .control_current_addr(control_current_addr),
      .bulk_head_addr(bulk_head_addr), .bulk_current_addr(bulk_current_addr),
      .done_queue_addr(done_queue_addr)
   );
   always #2.5 pclk = ~pclk;
   task chk(input string n, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   // the edge at the top keeps release and the next setup in separate steps
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task summarize;
      if (errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // the whole run needs under a hundred cycles
   always @(posedge pclk) if (++cyc == 2000) begin
      errors++;
      summarize();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      for (int i = 0; i < 6; i++) begin
         apb(0, ra[i], 0);
         chk("reset", rd, 0);
         apb(1, ra[i], 32'hFFFFFFFF);
         apb(0, ra[i], 0);
         chk("readback", rd, re[i]);
         chk("slverr", err, ee[i]);
      end
      // engine strobes race a software write to the bulk current pointer
      ctrl_cur_upd <= '{1'b1, 32'h1234567F};
      bulk_cur_upd <= '{1'b1, 32'hABCDEF0F};
      done_upd <= '{1'b1, 32'h0000BEEF};
      apb(1, 8'h2C, 32'h55555555);
      {ctrl_cur_upd, bulk_cur_upd, done_upd} <= '0;
      #1 chk("ctrl cur", control_current_addr, 32'h12345670);
      chk("bulk cur", bulk_current_addr, 32'hABCDEF00);
      apb(0, 8'h30, 0);
      chk("done", rd, 32'h0000BEE0);
      presetn <= 0;
      #1 chk("cleared", control_head_addr | control_current_addr | bulk_head_addr
         | bulk_current_addr | done_queue_addr, 0);
      repeat (4) @(posedge pclk);
      presetn <= 1;
      apb(0, 8'h2C, 0);
      chk("reset read", rd, 0);
      summarize();
   end
endmodule // testbench
